// file: triple_timer_counter_unit.v
// Three timer/counters with external interrupt flags and baud sources
// Function
// - External flag set on edge/level, cleared by service/write
// - Type bit picks falling edge or low level
// - Mode 0 uses 13 bits: high byte plus low five
// - Wrap to zero sets overflow flag
// - Count when run and (no gate or pin high)
// - Setting run bit keeps count intact
// - Gate bits at mode bit 7 and bit 3
// - Mode 1 is full sixteen-bit count
// - Mode 2 low byte reloads from high byte
// - Second timer in mode 3 holds count
// - First timer mode 3 splits into two bytes
// - First timer mode 3: second timer ignores its run bit, still gives baud
// - Third timer sixteen bits, timer or counter
// - Third timer mode decode from control bits and clock-out enable bit
// - Third overflow flag blocked in baud/clock-out
// - External flag on trigger fall when enabled and running, not in clock-out
// - Receive select picks third or second timer
// - Transmit select picks third or second timer
// - Baud mode high rollover reloads both bytes
// - Baud mode increments every oscillator clock as a timer, on pin falls as a counter
// - Baud mode trigger sets flag without reload
`timescale 1ns/1ps
`include "timer_unit_defines.vh"

module triple_timer_counter_unit (
    input  wire       clock,
    input  wire       rst,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    input  wire       irq_ack_ext0,
    input  wire       irq_ack_ext1,
    input  wire       irq_ack_t0,
    input  wire       irq_ack_t1,
    input  wire [1:0] external_interrupt_pin_n,
    input  wire [1:0] count_pin,
    input  wire       third_timer_count_pin,
    input  wire       third_timer_trigger_pin,
    output wire       ext_irq_zero_flag,
    output wire       ext_irq_one_flag,
    output wire       t0_overflow_flag,
    output wire       second_timer_overflow,
    output wire       third_timer_irq,
    output wire       clock_out,
    output wire       clock_out_oe_n,
    output wire       uart_rx_baud_tick,
    output wire       uart_tx_baud_tick,
    output wire       baud_t1_tick
);

    // ****************************************************************
    // Pin synchronisers and edge history
    // ****************************************************************
    reg  [5:0] sync1_q;
    reg  [5:0] sync2_q;
    reg  [5:0] prev_q;
    wire [5:0] pins = {third_timer_trigger_pin, third_timer_count_pin, count_pin,
                       external_interrupt_pin_n};
    wire [5:0] fall = prev_q & ~sync2_q;
    wire [1:0] int_lvl = sync2_q[1:0];

    always @(posedge clock) begin
        if (rst) begin
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
            prev_q  <= 6'h3F;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // ****************************************************************
    // Machine cycle prescaler
    // ****************************************************************
    reg  [2:0] pre_q;
    wire       mc_tick = (pre_q == `MACHINE_CYCLE_LAST);

    always @(posedge clock) begin
        if (rst)
            pre_q <= 3'h0;
        else
            pre_q <= mc_tick ? 3'h0 : pre_q + 3'h1;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [7:0] timer_control_q;
    reg  [7:0] timer_mode_reg_q;
    reg  [7:0] tl_q [0:1];
    reg  [7:0] th_q [0:1];
    reg  [7:0] third_timer_control_q;
    reg        clock_out_enable_q;
    reg  [7:0] reload_capture_low_q;
    reg  [7:0] reload_capture_high_q;
    reg  [7:0] third_timer_low_q;
    reg  [7:0] third_timer_high_q;
    reg        clk_out_q;

    function wr_hit;
        input [7:0] a;
        begin
            wr_hit = sfr_wr && (sfr_addr == a);
        end
    endfunction

    // ****************************************************************
    // General timers: tick enables
    // ****************************************************************
    wire [1:0] mode0 = timer_mode_reg_q[1:0];
    wire [1:0] mode1 = timer_mode_reg_q[5:4];
    wire       t0_split = (mode0 == 2'h3);
    wire [1:0] gate = {timer_mode_reg_q[`BIT_T1_GATE], timer_mode_reg_q[`BIT_T0_GATE]};
    wire [1:0] ct = {timer_mode_reg_q[6], timer_mode_reg_q[2]};
    wire [1:0] run = {timer_control_q[6], timer_control_q[4]};
    wire [1:0] src_tick;
    wire [1:0] tick;
    wire [1:0] ovf;
    wire       th0_ovf;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_timer
            wire [1:0] md = g ? mode1 : mode0;
            wire lo_full = (md == 2'h0) ? (tl_q[g][4:0] == 5'h1F) : (tl_q[g] == 8'hFF);
            assign src_tick[g] = ct[g] ? fall[2 + g] : mc_tick;
            // Timer 1 run gating does not apply to its baud role in split mode
            assign tick[g] = src_tick[g] && (g ? 1'b1 : run[0])
                           && (!gate[g] || int_lvl[g]);
            assign ovf[g] = tick[g] && lo_full && ((md == 2'h2) || (md == 2'h3) ||
                            (th_q[g] == 8'hFF));
            always @(posedge clock) begin
                if (rst) begin
                    tl_q[g] <= 8'h00;
                    th_q[g] <= 8'h00;
                end else if (wr_hit(g ? `ADDR_T1_LOW : `ADDR_T0_LOW)) begin
                    tl_q[g] <= sfr_wdata;
                end else if (wr_hit(g ? `ADDR_T1_HIGH : `ADDR_T0_HIGH)) begin
                    th_q[g] <= sfr_wdata;
                end else if (g == 1 && (md == 2'h3 || (!t0_split && !run[1]))) begin
                    tl_q[g] <= tl_q[g];
                end else if (tick[g]) begin
                    case (md)
                        2'h0: begin
                            tl_q[g] <= {3'h0, tl_q[g][4:0] + 5'h1};
                            if (lo_full)
                                th_q[g] <= th_q[g] + 8'h01;
                        end
                        2'h1: begin
                            tl_q[g] <= tl_q[g] + 8'h01;
                            if (lo_full)
                                th_q[g] <= th_q[g] + 8'h01;
                        end
                        2'h2: tl_q[g] <= lo_full ? th_q[g] : tl_q[g] + 8'h01;
                        default: tl_q[g] <= tl_q[g] + 8'h01;
                    endcase
                end
                // High byte of timer 0 in split mode counts machine cycles on run bit 1
                if (!rst && g == 0 && t0_split && mc_tick && run[1]
                    && !wr_hit(`ADDR_T0_HIGH)) begin
                    th_q[g] <= th_q[g] + 8'h01;
                end
            end
        end
    endgenerate

    assign th0_ovf = t0_split && mc_tick && run[1] && (th_q[0] == 8'hFF);
    wire t1_run_ok = t0_split ? (mode1 != 2'h3) : run[1];
    wire t1_ovf = ovf[1] && t1_run_ok && (mode1 != 2'h3);
    assign baud_t1_tick = t1_ovf;

    // ****************************************************************
    // Third timer
    // ****************************************************************
    wire t2_run  = third_timer_control_q[`BIT_T2_RUN];
    wire t2_baud = third_timer_control_q[`BIT_RX_SEL] | third_timer_control_q[`BIT_TX_SEL];
    wire t2_clko = !t2_baud && clock_out_enable_q;
    wire t2_cap  = !t2_baud && !clock_out_enable_q && third_timer_control_q[`BIT_T2_CPRL];
    // Baud and clock-out count every oscillator clock unless the counter bit selects pin edges
    wire t2_fast = t2_baud || t2_clko;
    wire t2_src  = third_timer_control_q[`BIT_T2_CT] ? fall[4] : (t2_fast ? 1'b1 : mc_tick);
    wire t2_tick = t2_run && t2_src;
    wire t2_ovf  = t2_tick && ({third_timer_high_q, third_timer_low_q} == 16'hFFFF);
    wire t2_trig = fall[5] && third_timer_control_q[`BIT_T2_EXEN] && !t2_clko;
    wire t2_count_wr = wr_hit(`ADDR_T2_LOW) || wr_hit(`ADDR_T2_HIGH);

    always @(posedge clock) begin
        if (rst) begin
            third_timer_low_q  <= 8'h00;
            third_timer_high_q <= 8'h00;
            clk_out_q          <= 1'b0;
        end else begin
            if (wr_hit(`ADDR_T2_LOW))
                third_timer_low_q <= sfr_wdata;
            if (wr_hit(`ADDR_T2_HIGH))
                third_timer_high_q <= sfr_wdata;
            if (!t2_count_wr && t2_tick) begin
                if (t2_ovf && (t2_baud || !t2_cap)) begin
                    third_timer_low_q  <= reload_capture_low_q;
                    third_timer_high_q <= reload_capture_high_q;
                end else begin
                    {third_timer_high_q, third_timer_low_q} <=
                        {third_timer_high_q, third_timer_low_q} + 16'h0001;
                end
            end else if (!t2_count_wr && t2_trig && t2_run && !t2_baud && !t2_cap) begin
                third_timer_low_q  <= reload_capture_low_q;
                third_timer_high_q <= reload_capture_high_q;
            end
            if (t2_ovf && t2_clko)
                clk_out_q <= ~clk_out_q;
        end
    end

    // ****************************************************************
    // Control registers and flags
    // ****************************************************************
    // Hardware set beats software clear in the same cycle
    wire [1:0] ext_set;
    assign ext_set[0] = timer_control_q[0] ? fall[0] : !int_lvl[0];
    assign ext_set[1] = timer_control_q[2] ? fall[1] : !int_lvl[1];
    wire t0_set = ovf[0];
    wire t1_set = t0_split ? th0_ovf : t1_ovf;

    always @(posedge clock) begin
        if (rst) begin
            timer_control_q                <= 8'h00;
            timer_mode_reg_q      <= 8'h00;
            third_timer_control_q               <= `T2_CONTROL_RESET;
            clock_out_enable_q    <= 1'b0;
            reload_capture_low_q  <= 8'h00;
            reload_capture_high_q <= 8'h00;
        end else begin
            if (wr_hit(`ADDR_TIMER_CONTROL))
                timer_control_q <= sfr_wdata;
            if (irq_ack_ext0)
                timer_control_q[1] <= 1'b0;
            if (irq_ack_ext1)
                timer_control_q[3] <= 1'b0;
            if (irq_ack_t0)
                timer_control_q[5] <= 1'b0;
            if (irq_ack_t1)
                timer_control_q[7] <= 1'b0;
            if (ext_set[0])
                timer_control_q[1] <= 1'b1;
            if (ext_set[1])
                timer_control_q[3] <= 1'b1;
            if (t0_set)
                timer_control_q[5] <= 1'b1;
            if (t1_set)
                timer_control_q[7] <= 1'b1;
            if (wr_hit(`ADDR_TIMER_MODE))
                timer_mode_reg_q <= sfr_wdata;
            if (wr_hit(`ADDR_T2_MODE))
                clock_out_enable_q <= sfr_wdata[1];
            if (wr_hit(`ADDR_T2_CONTROL))
                third_timer_control_q <= sfr_wdata;
            if (t2_ovf && !t2_baud && !t2_clko)
                third_timer_control_q[`BIT_T2_OVF] <= 1'b1;
            if (t2_trig && t2_run)
                third_timer_control_q[`BIT_T2_EXF] <= 1'b1;
            if (wr_hit(`ADDR_RELOAD_LOW))
                reload_capture_low_q <= sfr_wdata;
            if (wr_hit(`ADDR_RELOAD_HIGH))
                reload_capture_high_q <= sfr_wdata;
            if (t2_trig && t2_run && t2_cap) begin
                reload_capture_low_q  <= third_timer_low_q;
                reload_capture_high_q <= third_timer_high_q;
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @(posedge clock) begin
        if (rst)
            sfr_rdata <= 8'h00;
        else begin
            case (sfr_addr)
                `ADDR_TIMER_CONTROL: sfr_rdata <= timer_control_q;
                `ADDR_TIMER_MODE:    sfr_rdata <= timer_mode_reg_q;
                `ADDR_T0_LOW:        sfr_rdata <= tl_q[0];
                `ADDR_T1_LOW:        sfr_rdata <= tl_q[1];
                `ADDR_T0_HIGH:       sfr_rdata <= th_q[0];
                `ADDR_T1_HIGH:       sfr_rdata <= th_q[1];
                `ADDR_T2_CONTROL:    sfr_rdata <= third_timer_control_q;
                `ADDR_T2_MODE:       sfr_rdata <= {6'h00, clock_out_enable_q, 1'b0};
                `ADDR_RELOAD_LOW:    sfr_rdata <= reload_capture_low_q;
                `ADDR_RELOAD_HIGH:   sfr_rdata <= reload_capture_high_q;
                `ADDR_T2_LOW:        sfr_rdata <= third_timer_low_q;
                `ADDR_T2_HIGH:       sfr_rdata <= third_timer_high_q;
                default:             sfr_rdata <= 8'h00;
            endcase
        end
    end

    assign ext_irq_zero_flag     = timer_control_q[1];
    assign ext_irq_one_flag      = timer_control_q[3];
    assign t0_overflow_flag      = timer_control_q[5];
    assign second_timer_overflow = timer_control_q[7];
    assign third_timer_irq       = third_timer_control_q[`BIT_T2_OVF] | third_timer_control_q[`BIT_T2_EXF];
    assign clock_out             = clk_out_q;
    assign clock_out_oe_n        = !t2_clko;
    // Baud ticks are one-cycle pulses; UART divides by 16 itself
    assign uart_rx_baud_tick = third_timer_control_q[`BIT_RX_SEL] ? (t2_ovf && t2_baud) : t1_ovf;
    assign uart_tx_baud_tick = third_timer_control_q[`BIT_TX_SEL] ? (t2_ovf && t2_baud) : t1_ovf;

endmodule // triple_timer_counter_unit

// file: timer_unit_defines.vh
// Register addresses, bit positions and timing constants for the timer unit
`ifndef TIMER_UNIT_DEFINES_VH
`define TIMER_UNIT_DEFINES_VH
// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_TIMER_CONTROL  8'h88
`define ADDR_TIMER_MODE     8'h89
`define ADDR_T0_LOW         8'h8A
`define ADDR_T1_LOW         8'h8B
`define ADDR_T0_HIGH        8'h8C
`define ADDR_T1_HIGH        8'h8D
`define ADDR_T2_CONTROL     8'hC8
`define ADDR_T2_MODE        8'hC9
`define ADDR_RELOAD_LOW     8'hCA
`define ADDR_RELOAD_HIGH    8'hCB
`define ADDR_T2_LOW         8'hCC
`define ADDR_T2_HIGH        8'hCD
// ****************************************************************
// Reset values and bit positions
// ****************************************************************
`define T2_CONTROL_RESET    8'h00
`define BIT_T2_OVF          7
`define BIT_T2_EXF          6
`define BIT_RX_SEL          5
`define BIT_TX_SEL          4
`define BIT_T2_EXEN         3
`define BIT_T2_RUN          2
`define BIT_T2_CT           1
`define BIT_T2_CPRL         0
`define BIT_T1_GATE         7
`define BIT_T0_GATE         3
// ****************************************************************
// Timing: machine cycle in oscillator clocks
// ****************************************************************
`define MACHINE_CYCLE_CLKS  6
`define MACHINE_CYCLE_LAST  3'h5
`endif

// file: timer_unit_assertions.sv
// Port-level concurrent checks for the triple timer unit
`timescale 1ns/1ps
`include "timer_unit_defines.vh"
module timer_unit_checker (
    input wire       clock,
    input wire       rst,
    input wire [7:0] sfr_addr,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire [1:0] external_interrupt_pin_n,
    input wire       third_timer_trigger_pin,
    input wire       ext_irq_zero_flag,
    input wire       ext_irq_one_flag,
    input wire       t0_overflow_flag,
    input wire       second_timer_overflow,
    input wire       third_timer_irq,
    input wire       clock_out_oe_n,
    input wire       uart_rx_baud_tick,
    input wire       uart_tx_baud_tick,
    input wire       baud_t1_tick
);
    // ****
    // Mirrors of software-only bits
    // ****
    reg [7:0] tc_q;
    reg [7:0] t2_q;
    reg       oe_q;
    // Pin history wide enough to cover the two-stage synchroniser plus edge detect
    reg [5:0] p0_q = 6'h3F;
    reg [5:0] p1_q = 6'h3F;
    reg [5:0] tr_q = 6'h3F;
    wire      tc_wr = sfr_wr && sfr_addr == `ADDR_TIMER_CONTROL;
    wire      t2_wr = sfr_wr && sfr_addr == `ADDR_T2_CONTROL;
    always @(posedge clock) begin
        p0_q <= {p0_q[4:0], external_interrupt_pin_n[0]};
        p1_q <= {p1_q[4:0], external_interrupt_pin_n[1]};
        tr_q <= {tr_q[4:0], third_timer_trigger_pin};
        if (rst) begin
            tc_q <= 8'h00;
            t2_q <= 8'h00;
            oe_q <= 1'b0;
        end else if (sfr_wr) begin
            if (tc_wr) tc_q <= sfr_wdata;
            if (t2_wr) t2_q <= sfr_wdata;
            if (sfr_addr == `ADDR_T2_MODE) oe_q <= sfr_wdata[1];
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_baud_rise;
        (t2_q[5] || t2_q[4]) ##0 $rose(third_timer_irq);
    endsequence
    property p_ext0_cause;
        $rose(ext_irq_zero_flag) |-> !(&p0_q) || $past(tc_wr && sfr_wdata[1]);
    endproperty
    property p_ext1_cause;
        $rose(ext_irq_one_flag) |-> !(&p1_q) || $past(tc_wr && sfr_wdata[3]);
    endproperty
    property p_t0_run;
        $rose(t0_overflow_flag) |-> tc_q[4] || $past(tc_q[4], 2) || $past(tc_wr && sfr_wdata[5]);
    endproperty
    property p_t1_run;
        $rose(second_timer_overflow) |-> tc_q[6] || $past(tc_q[6], 2) || $past(tc_wr && sfr_wdata[7]);
    endproperty
    property p_t2_baud_flag;
        s_baud_rise |-> !(&tr_q) || $past(t2_wr);
    endproperty
    property p_rx_src;
        uart_rx_baud_tick |-> t2_q[5] || baud_t1_tick;
    endproperty
    property p_tx_src;
        uart_tx_baud_tick |-> t2_q[4] || baud_t1_tick;
    endproperty
    property p_oe;
        !clock_out_oe_n |-> oe_q || $past(oe_q);
    endproperty
    a_ext0_cause: assert property (p_ext0_cause) else $error("ext0 flag rose without cause");
    a_ext1_cause: assert property (p_ext1_cause) else $error("ext1 flag rose without cause");
    a_t0_run: assert property (p_t0_run) else $error("t0 overflow while stopped");
    a_t1_run: assert property (p_t1_run) else $error("t1 overflow flag while stopped");
    a_t2_baud_flag: assert property (p_t2_baud_flag) else $error("t2 flag in baud mode");
    a_rx_src: assert property (p_rx_src) else $error("rx tick from wrong source");
    a_tx_src: assert property (p_tx_src) else $error("tx tick from wrong source");
    a_oe: assert property (p_oe) else $error("clock out driven when disabled");
endmodule // timer_unit_checker

bind triple_timer_counter_unit timer_unit_checker chk_u (.clock, .rst, .sfr_addr, .sfr_wr,
    .sfr_wdata, .external_interrupt_pin_n, .third_timer_trigger_pin, .ext_irq_zero_flag,
    .ext_irq_one_flag, .t0_overflow_flag, .second_timer_overflow, .third_timer_irq,
    .clock_out_oe_n, .uart_rx_baud_tick, .uart_tx_baud_tick, .baud_t1_tick);

// file: pin_model.sv
// Pin-side partner: pulled-up interrupt, trigger and event pins
`timescale 1ns/1ps
module pin_model (
    input  wire       clock,
    input  wire [1:0] int_low,
    input  wire       trig_low,
    input  wire [2:0] cnt_low,
    output reg  [1:0] int_pin_n = 2'h3,
    output reg        trig_pin = 1'b1,
    output reg  [2:0] cnt_pin = 3'h7
);
    // ****
    // Pin drivers
    // ****
    // Pins start on their pull-ups so no false edge follows reset
    // Falling-edge drive keeps pin changes away from the sampling edge
    always @(negedge clock) begin
        int_pin_n <= ~int_low;
        trig_pin <= ~trig_low;
        cnt_pin <= ~cnt_low;
    end
endmodule // pin_model

// file: tb_top.sv
// Self-checking bench for the triple timer unit
`timescale 1ns/1ps
`include "timer_unit_defines.vh"
module tb_top;
    reg         clock = 1'b0;
    reg         rst = 1'b1;
    reg  [7:0]  sfr_addr = 8'h00;
    reg         sfr_wr = 1'b0;
    reg  [7:0]  sfr_wdata = 8'h00;
    reg  [3:0]  ack = 4'h0;
    reg  [1:0]  int_low = 2'h0;
    reg         trig_low = 1'b0;
    reg  [2:0]  cnt_low = 3'h0;
    reg  [31:0] lfsr = 32'h000137CB;
    integer     error_cnt = 0;
    integer     num_checks = 0;
    integer     i, n;
    reg  [7:0]  d, v, h;
    wire [7:0]  sfr_rdata;
    wire [1:0]  int_pin_n;
    wire [2:0]  cnt_pin;
    wire        trig_pin, f_e0, f_e1, f_t0, f_t1, f_t2, clk_out, oe_n, rx_tick, tx_tick, t1_tick;
    wire [7:0]  w = {t1_tick, f_e1, f_e0, clk_out, tx_tick, f_t2, f_t1, f_t0};
    always #5 clock = ~clock;
    triple_timer_counter_unit dut_u (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_ack_ext0(ack[0]),
        .irq_ack_ext1(ack[1]), .irq_ack_t0(ack[2]), .irq_ack_t1(ack[3]),
        .external_interrupt_pin_n(int_pin_n), .count_pin(cnt_pin[1:0]),
        .third_timer_count_pin(cnt_pin[2]), .third_timer_trigger_pin(trig_pin),
        .ext_irq_zero_flag(f_e0), .ext_irq_one_flag(f_e1), .t0_overflow_flag(f_t0),
        .second_timer_overflow(f_t1), .third_timer_irq(f_t2), .clock_out(clk_out),
        .clock_out_oe_n(oe_n), .uart_rx_baud_tick(rx_tick), .uart_tx_baud_tick(tx_tick),
        .baud_t1_tick(t1_tick));
    pin_model model_u (.clock(clock), .int_low(int_low), .trig_low(trig_low), .cnt_low(cnt_low),
        .int_pin_n(int_pin_n), .trig_pin(trig_pin), .cnt_pin(cnt_pin));
    // ****
    // Helpers
    // ****
    function [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        rnd = lfsr[7:0];
    endfunction
    function [7:0] tl_init(input integer m);
        tl_init = (m == 0) ? 8'h1F : ((m == 1) ? 8'hFE : 8'hFF);
    endfunction
    function [7:0] exp_high(input integer m, input [7:0] rl);
        exp_high = (m == 2) ? rl : 8'h00;
    endfunction
    function [7:0] baud_clks(input [7:0] lo);
        baud_clks = 8'h00 - lo;
    endfunction
    task wr(input [7:0] a, input [7:0] dt);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = dt;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask
    task rd(input [7:0] a, output [7:0] dt);
        @(negedge clock);
        sfr_addr = a;
        @(negedge clock);
        dt = sfr_rdata;
    endtask
    task pulse(input [3:0] m);
        @(negedge clock);
        ack = m;
        @(negedge clock);
        ack = 4'h0;
        @(negedge clock);
    endtask
    task trig();
        trig_low = 1'b1;
        repeat (8) @(negedge clock);
        trig_low = 1'b0;
    endtask
    task wait_bit(input integer b, input lvl, input integer lim);
        n = 0;
        while (w[b] !== lvl && n < lim) begin
            @(negedge clock);
            n = n + 1;
        end
    endtask
    task cmp8(input string nm, input [7:0] e, input [7:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cmp1(input string nm, input e, input g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Far longer than the sequence needs, so only a hang reaches it
    initial begin
        #300000;
        error_cnt = error_cnt + 1;
        test_done();
    end
    // ****
    // Tests
    // ****
    initial begin
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rd(`ADDR_T2_CONTROL, v);
        cmp8("t2_control_reset", `T2_CONTROL_RESET, v);
        rd(8'h90, v);
        cmp8("unmapped_read", 8'h00, v);
        for (i = 0; i < 3; i = i + 1) begin
            h = rnd();
            int_low = 2'h1;
            wr(`ADDR_TIMER_MODE, 8'h08 | i[7:0]);
            wr(`ADDR_T0_HIGH, (i == 2) ? h : 8'hFF);
            wr(`ADDR_T0_LOW, tl_init(i));
            wr(`ADDR_TIMER_CONTROL, 8'h10);
            repeat (20) @(negedge clock);
            rd(`ADDR_T0_LOW, v);
            cmp8("t0_low_gated", tl_init(i), v);
            int_low = 2'h0;
            wait_bit(0, 1'b1, 80);
            cmp1("t0_flag", 1'b1, f_t0);
            rd(`ADDR_T0_HIGH, v);
            cmp8("t0_high", exp_high(i, h), v);
            wr(`ADDR_TIMER_CONTROL, 8'h20);
            pulse(4'h4);
            cmp1("t0_flag_ack", 1'b0, f_t0);
        end
        wr(`ADDR_TIMER_MODE, 8'h03);
        wr(`ADDR_T0_HIGH, 8'hFF);
        wr(`ADDR_TIMER_CONTROL, 8'h40);
        wait_bit(1, 1'b1, 80);
        cmp1("t1_flag_from_t0_high", 1'b1, f_t1);
        wr(`ADDR_TIMER_CONTROL, 8'h00);
        wr(`ADDR_TIMER_MODE, 8'h23);
        wr(`ADDR_T1_HIGH, 8'hFF);
        wr(`ADDR_T1_LOW, 8'hFF);
        wait_bit(7, 1'b1, 20);
        cmp1("t1_baud_tick_split", 1'b1, t1_tick);
        wr(`ADDR_TIMER_MODE, 8'h33);
        wr(`ADDR_T1_LOW, 8'h5A);
        repeat (20) @(negedge clock);
        rd(`ADDR_T1_LOW, v);
        cmp8("t1_held_mode3", 8'h5A, v);
        wr(`ADDR_TIMER_MODE, 8'h00);
        $display("test general_timers done");
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_TIMER_CONTROL, {5'h00, i[0] & i[1], 1'b0, i[0] & ~i[1]});
            int_low = 2'h1 << i[1];
            repeat (10) @(negedge clock);
            cmp1("ext_flag_set", 1'b1, w[5 + i[1]]);
            pulse(4'h1 << i[1]);
            cmp1("ext_flag_held_low", ~i[0], w[5 + i[1]]);
            int_low = 2'h0;
            repeat (6) @(negedge clock);
            pulse(4'h1 << i[1]);
            cmp1("ext_flag_clear", 1'b0, w[5 + i[1]]);
        end
        $display("test ext_interrupts done");
        d = 8'h03 + (rnd() & 8'h07);
        v = 8'h00 - d;
        wr(`ADDR_RELOAD_HIGH, 8'hFF);
        wr(`ADDR_RELOAD_LOW, v);
        wr(`ADDR_T2_HIGH, 8'hFF);
        wr(`ADDR_T2_LOW, v);
        rd(`ADDR_RELOAD_LOW, h);
        cmp8("reload_low", v, h);
        wr(`ADDR_T2_CONTROL, 8'h1C);
        wait_bit(3, 1'b1, 100);
        wait_bit(3, 1'b0, 100);
        wait_bit(3, 1'b1, 100);
        cmp8("baud_period", baud_clks(v), n[7:0] + 8'h01);
        cmp1("rx_tick_second_timer", 1'b0, rx_tick);
        wr(`ADDR_T2_CONTROL, 8'h3C);
        wait_bit(3, 1'b1, 100);
        cmp1("rx_tick_third_timer", 1'b1, rx_tick);
        trig();
        rd(`ADDR_T2_CONTROL, v);
        cmp8("baud_flags", 8'h7C, v);
        wr(`ADDR_T2_CONTROL, 8'h00);
        $display("test baud done");
        h = rnd();
        wr(`ADDR_T2_HIGH, h);
        wr(`ADDR_T2_LOW, 8'h00);
        wr(`ADDR_T2_CONTROL, 8'h0D);
        trig();
        rd(`ADDR_T2_CONTROL, v);
        cmp8("capture_flags", 8'h4D, v);
        rd(`ADDR_RELOAD_HIGH, v);
        cmp8("capture_high", h, v);
        wr(`ADDR_T2_CONTROL, 8'h00);
        h = rnd();
        wr(`ADDR_RELOAD_HIGH, h);
        wr(`ADDR_RELOAD_LOW, 8'h00);
        wr(`ADDR_T2_HIGH, 8'hFF);
        wr(`ADDR_T2_LOW, 8'hFE);
        wr(`ADDR_T2_CONTROL, 8'h04);
        wait_bit(2, 1'b1, 80);
        rd(`ADDR_T2_CONTROL, v);
        cmp8("t2_overflow", 8'h84, v);
        rd(`ADDR_T2_HIGH, v);
        cmp8("t2_reloaded", h, v);
        wr(`ADDR_T2_CONTROL, 8'h00);
        $display("test capture_reload done");
        wr(`ADDR_RELOAD_HIGH, 8'hFF);
        wr(`ADDR_RELOAD_LOW, 8'hF0);
        wr(`ADDR_T2_HIGH, 8'hFF);
        wr(`ADDR_T2_LOW, 8'hF0);
        wr(`ADDR_T2_MODE, 8'h02);
        wr(`ADDR_T2_CONTROL, 8'h04);
        wait_bit(4, 1'b1, 40);
        wait_bit(4, 1'b0, 40);
        cmp8("clock_out_half", 8'h10, n[7:0]);
        cmp1("clock_out_driven", 1'b0, oe_n);
        cmp1("no_flag_clock_out", 1'b0, f_t2);
        wr(`ADDR_T2_CONTROL, 8'h00);
        wr(`ADDR_T2_MODE, 8'h00);
        $display("test clock_out done");
        d = 8'h01 + (rnd() & 8'h07);
        wr(`ADDR_T2_LOW, 8'h00);
        wr(`ADDR_T2_CONTROL, 8'h06);
        for (i = 0; i < d; i = i + 1) begin
            cnt_low = 3'h4;
            repeat (4) @(negedge clock);
            cnt_low = 3'h0;
            repeat (4) @(negedge clock);
        end
        rd(`ADDR_T2_LOW, v);
        cmp8("t2_event_count", d, v);
        wr(`ADDR_T2_CONTROL, 8'h00);
        $display("test event_count done");
        test_done();
    end
endmodule // tb_top
